// ### etac_top.v
// External trigger acquisition sequencer for a detector array
`timescale 1ns/1ps
`include "etac_regs.vh"
module etac_top (
    input  wire       CLOCK_I,       // 40 MHz clock
    input  wire       SRST_I,        // Synchronous reset, active high
    input  wire [1:0] MODE_I,        // Acquisition mode select
    input  wire [1:0] CONV_I,        // Converter speed option
    input  wire       JMP_PAIR12_I,  // Jumper pins 1-2 shorted
    input  wire       JMP_PAIR34_I,  // Jumper pins 3-4 shorted
    input  wire       TRIG_SYNC_I,   // Synchronisation trigger pin
    input  wire       TRIG_HARD_I,   // Hardware trigger pin
    input  wire       TRIG_SOFT_I,   // Software level trigger pin
    output reg        CLEAR_O,       // Array clear pulse
    output reg        INTEG_O,       // Array integrating
    output reg        XFER_O,        // Scan handed to host, pulse per cycle
    output reg        SCAN_DONE_O,   // One pulse per delivered scan
    output reg        BUSY_O         // Not idle
);
    localparam ST_IDLE  = 2'h0;
    localparam ST_CLEAR = 2'h1;
    localparam ST_INTEG = 2'h2;
    localparam ST_XFER  = 2'h3;

    // Cycles for a period code and converter option
    function [31:0] period_cyc;
        input [1:0] conv;
        input [1:0] code;
        reg   [31:0] us;
        begin
            us = `ETAC_T_FAST0_US;
            case ({conv, code})
                4'h0: us = `ETAC_T_FAST0_US;
                4'h1: us = `ETAC_T_FAST1_US;
                4'h2: us = `ETAC_T_FAST2_US;
                4'h3: us = `ETAC_T_FAST3_US;
                4'h4: us = `ETAC_T_MID0_US;
                4'h5: us = `ETAC_T_MID1_US;
                4'h6: us = `ETAC_T_MID2_US;
                4'h7: us = `ETAC_T_MID3_US;
                4'h8: us = `ETAC_T_SLOW0_US;
                4'h9: us = `ETAC_T_SLOW1_US;
                4'hA: us = `ETAC_T_SLOW2_US;
                4'hB: us = `ETAC_T_SLOW3_US;
                default: us = `ETAC_T_SLOW3_US;
            endcase
            period_cyc = us * `ETAC_CYC_PER_US;
        end
    endfunction

    // Whether an idle sequencer starts a scan in the given mode
    function idle_go;
        input [1:0] mode;
        input       s_edge;
        input       h_edge;
        begin
            case (mode)
                `ETAC_MODE_NORMAL: idle_go = 1'b1;
                `ETAC_MODE_SOFT:   idle_go = 1'b1;
                `ETAC_MODE_SYNC:   idle_go = s_edge;
                `ETAC_MODE_HARD:   idle_go = h_edge;
                default:           idle_go = 1'b0;
            endcase
        end
    endfunction

    // Bit positions of the pins in the synchroniser bank
    localparam IDX_SYNC = 0;
    localparam IDX_HARD = 1;
    localparam IDX_SOFT = 2;
    localparam IDX_J34  = 3;
    localparam IDX_J12  = 4;

    // Two-stage synchronisers for every pin input
    localparam NSYNC = 5;
    wire [NSYNC-1:0] pin_raw = {JMP_PAIR12_I, JMP_PAIR34_I, TRIG_SOFT_I,
                                TRIG_HARD_I, TRIG_SYNC_I};
    reg  [NSYNC-1:0] meta_q;
    reg  [NSYNC-1:0] sync_q;
    reg  [NSYNC-1:0] prev_q;
    genvar g;
    generate
        for (g = 0; g < NSYNC; g = g + 1) begin : g_sync
            always @(posedge CLOCK_I) begin
                if (SRST_I) begin
                    meta_q[g] <= 1'b0;
                    sync_q[g] <= 1'b0;
                    prev_q[g] <= 1'b0;
                end else begin
                    meta_q[g] <= pin_raw[g];
                    sync_q[g] <= meta_q[g];
                    prev_q[g] <= sync_q[g];
                end
            end
        end
    endgenerate

    wire       sync_edge = sync_q[IDX_SYNC] & ~prev_q[IDX_SYNC];
    wire       hard_edge = sync_q[IDX_HARD] & ~prev_q[IDX_HARD];
    wire       soft_lvl  = sync_q[IDX_SOFT];
    wire [1:0] jmp_code  = {sync_q[IDX_J12], sync_q[IDX_J34]};

    reg [1:0]  state_q;
    reg [1:0]  state_d;
    reg [31:0] cnt_q;
    reg [31:0] cnt_d;
    reg [1:0]  mode_q;
    reg        clear_d;
    reg        integ_d;
    reg        xfer_d;
    reg        done_d;

    // Idle decides on the live mode, so no stale mode starts a scan after reset
    wire [1:0] mode_now = (state_q == ST_IDLE) ? MODE_I : mode_q;

    always @* begin
        state_d = state_q;
        cnt_d   = cnt_q + 32'h1;
        clear_d = 1'b0;
        integ_d = 1'b0;
        xfer_d  = 1'b0;
        done_d  = 1'b0;
        case (state_q)
            ST_IDLE: begin
                cnt_d = 32'h0;
                if (idle_go(mode_now, sync_edge, hard_edge)) begin
                    state_d = ST_CLEAR;
                end
            end
            ST_CLEAR: begin
                clear_d = 1'b1;
                cnt_d   = 32'h0;
                state_d = ST_INTEG;
            end
            ST_INTEG: begin
                integ_d = 1'b1;
                case (mode_q)
                    `ETAC_MODE_SYNC: begin
                        cnt_d = 32'h0;
                        if (sync_edge) begin
                            state_d = ST_XFER;
                        end
                    end
                    `ETAC_MODE_HARD: begin
                        // Edges here are ignored, missed acquisitions are the user's
                        if (cnt_q + 32'h1 >= period_cyc(CONV_I, jmp_code)) begin
                            state_d = ST_XFER;
                        end
                    end
                    default: begin
                        if (cnt_q + 32'h1 >= `ETAC_FREE_US * `ETAC_CYC_PER_US) begin
                            state_d = ST_XFER;
                        end
                    end
                endcase
                if (state_d == ST_XFER) begin
                    cnt_d = 32'h0;
                end
            end
            ST_XFER: begin
                // Software mode only forwards while the level is high
                xfer_d = (mode_q != `ETAC_MODE_SOFT) | soft_lvl;
                if (cnt_q == `ETAC_XFER_CYC - 1) begin
                    done_d  = xfer_d;
                    cnt_d   = 32'h0;
                    if (mode_q == `ETAC_MODE_HARD) begin
                        state_d = ST_IDLE;
                    end else begin
                        state_d = ST_CLEAR;
                    end
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always @(posedge CLOCK_I) begin
        if (SRST_I) begin
            state_q     <= ST_IDLE;
            cnt_q       <= 32'h0;
            mode_q      <= 2'h0;
            CLEAR_O     <= 1'b0;
            INTEG_O     <= 1'b0;
            XFER_O      <= 1'b0;
            SCAN_DONE_O <= 1'b0;
            BUSY_O      <= 1'b0;
        end else begin
            // Mode change only takes effect while idle to avoid torn scans
            if (state_q == ST_IDLE) begin
                mode_q <= MODE_I;
            end
            state_q     <= state_d;
            cnt_q       <= cnt_d;
            CLEAR_O     <= clear_d;
            INTEG_O     <= integ_d;
            XFER_O      <= xfer_d;
            SCAN_DONE_O <= done_d;
            // Held through the last transfer cycle so idle never overlaps data
            BUSY_O      <= (state_q != ST_IDLE) | (state_d != ST_IDLE);
        end
    end
endmodule

// ### etac_regs.vh
// Constants for the external trigger acquisition sequencer
`ifndef ETAC_REGS_VH
`define ETAC_REGS_VH
`define ETAC_CLK_HZ         40000000
`define ETAC_MODE_NORMAL    2'h0
`define ETAC_MODE_SOFT      2'h1
`define ETAC_MODE_SYNC      2'h2
`define ETAC_MODE_HARD      2'h3
`define ETAC_CONV_FAST      2'h0
`define ETAC_CONV_MID       2'h1
`define ETAC_CONV_SLOW      2'h2
// Integration times in microseconds, code order 0..3
`define ETAC_T_FAST0_US     4400
`define ETAC_T_FAST1_US     13300
`define ETAC_T_FAST2_US     27500
`define ETAC_T_FAST3_US     67500
`define ETAC_T_MID0_US      8800
`define ETAC_T_MID1_US      27500
`define ETAC_T_MID2_US      55000
`define ETAC_T_MID3_US      137500
`define ETAC_T_SLOW0_US     44000
`define ETAC_T_SLOW1_US     133000
`define ETAC_T_SLOW2_US     275000
`define ETAC_T_SLOW3_US     675000
`define ETAC_CYC_PER_US     (`ETAC_CLK_HZ / 1000000)
`define ETAC_FREE_US        4400
`define ETAC_XFER_CYC       16
`endif

// ### etac_trig_model.sv
// Model of the external triggering device
`timescale 1ns/1ps
module etac_trig_model (
    input  wire       clk_i,  // Sequencer clock
    output reg  [2:0] trig_o  // 0 sync, 1 hardware, 2 software
);
    initial trig_o = 3'h0;
    // Logic-level pulse; caller spaces pulses by the wanted exposure
    task pulse(input integer idx);
        begin
            @(posedge clk_i) #1 trig_o[idx] = 1'b1;
            repeat (4) @(posedge clk_i);
            #1 trig_o[idx] = 1'b0;
        end
    endtask
endmodule

// ### etac_top_assertions.sv
// Concurrent checks for the acquisition sequencer
`timescale 1ns/1ps
`include "etac_regs.vh"
module etac_checker (
    input wire       CLOCK_I,      // Clock
    input wire       SRST_I,       // Reset
    input wire [1:0] MODE_I,       // Mode
    input wire       TRIG_SYNC_I,  // Sync trigger
    input wire       CLEAR_O,      // Clear pulse
    input wire       INTEG_O,      // Integrating
    input wire       XFER_O,       // Transfer
    input wire       SCAN_DONE_O,  // Scan done
    input wire       BUSY_O        // Busy
);
    reg  [24:0] integ_cnt_q;
    reg  [5:0]  xfer_run_q;
    wire        sync_m = MODE_I == `ETAC_MODE_SYNC;
    wire        hard_m = MODE_I == `ETAC_MODE_HARD;
    always @(posedge CLOCK_I) begin
        if (SRST_I) begin
            integ_cnt_q <= 25'h0;
            xfer_run_q  <= 6'h0;
        end else begin
            integ_cnt_q <= INTEG_O ? integ_cnt_q + 25'h1 : 25'h0;
            xfer_run_q  <= XFER_O ? xfer_run_q + 6'h1 : 6'h0;
        end
    end
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (SRST_I);
    sequence s_new_scan; ##[0:2] CLEAR_O ##1 INTEG_O; endsequence
    a_clear_one_cycle: assert property (CLEAR_O |=> !CLEAR_O)
        else $error("clear pulse too long");
    a_integ_after_clear: assert property (CLEAR_O |=> INTEG_O)
        else $error("no integration after clear");
    a_xfer_sixteen: assert property (sync_m && $fell(XFER_O) |-> xfer_run_q == 6'h10)
        else $error("transfer length wrong");
    a_done_on_last: assert property (sync_m && SCAN_DONE_O |-> XFER_O ##1 !XFER_O)
        else $error("scan done misplaced");
    a_sync_fresh_scan: assert property (sync_m && $fell(XFER_O) |-> s_new_scan)
        else $error("no fresh scan after transfer");
    a_idle_is_quiet: assert property (!BUSY_O |-> !INTEG_O && !XFER_O)
        else $error("activity while idle");
    a_sync_first_edge: assert property (sync_m && !BUSY_O && $rose(TRIG_SYNC_I)
        |-> ##[1:6] CLEAR_O)
        else $error("first edge not answered");
    a_sync_integ_end: assert property (sync_m && $fell(INTEG_O) |-> ##[0:2] XFER_O)
        else $error("integration ended without hand-over");
    a_hard_full_period: assert property (hard_m && $fell(INTEG_O)
        |-> integ_cnt_q >= 25'h2AF7F)
        else $error("hardware integration too short");
    a_hard_edge_ignore: assert property (hard_m && CLEAR_O |-> !$past(BUSY_O, 2))
        else $error("edge accepted during integration");
endmodule
bind etac_top etac_checker i_chk (.*);

// ### external_trigger_acquisition_control_tb_top.sv
// Self-checking bench for the acquisition sequencer
`timescale 1ns/1ps
`include "etac_regs.vh"
module external_trigger_acquisition_control_tb_top;
    reg        CLOCK_I = 1'b0;
    reg        SRST_I  = 1'b1;
    reg  [1:0] MODE_I  = `ETAC_MODE_SYNC;
    reg  [1:0] CONV_I  = `ETAC_CONV_FAST;
    reg  [1:0] jmp     = 2'h0;
    reg        xq      = 1'b0;
    wire [2:0] trig;
    wire       CLEAR_O, INTEG_O, XFER_O, SCAN_DONE_O, BUSY_O;
    integer    n_mismatch = 0, compares = 0, cyc = 0, t0 = 0, t1 = 0, n, m, d, s;
    always #12.5 CLOCK_I = ~CLOCK_I;
    always @(posedge CLOCK_I) begin
        cyc <= cyc + 1;
        xq <= XFER_O;
        if (XFER_O && !xq) begin
            t0 <= t1;
            t1 <= cyc;
        end
    end
    etac_trig_model i_trig (.clk_i(CLOCK_I), .trig_o(trig));
    etac_top i_dut (.CLOCK_I(CLOCK_I), .SRST_I(SRST_I), .MODE_I(MODE_I), .CONV_I(CONV_I),
        .JMP_PAIR12_I(jmp[1]), .JMP_PAIR34_I(jmp[0]), .TRIG_SYNC_I(trig[0]),
        .TRIG_HARD_I(trig[1]), .TRIG_SOFT_I(trig[2]), .CLEAR_O(CLEAR_O), .INTEG_O(INTEG_O),
        .XFER_O(XFER_O), .SCAN_DONE_O(SCAN_DONE_O), .BUSY_O(BUSY_O));
    task step; @(posedge CLOCK_I) #1; endtask
    task chk(input [95:0] name, input [31:0] seen, input [31:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("unexpected %0s expected %0h seen %0h", name, exp, seen);
            end
        end
    endtask
    // Bounded wait: 0 for clear, 1 for transfer
    task wait_sig(input integer which);
        begin
            n = 0;
            while ((which ? XFER_O : CLEAR_O) !== 1'b1 && n < 20) begin
                step;
                n = n + 1;
            end
        end
    endtask
    task test_sync;
        begin
            repeat (50) step;
            chk("idle busy", BUSY_O, 0);
            i_trig.pulse(0);
            wait_sig(0);
            chk("first clear", CLEAR_O, 1);
            repeat (300) step;
            chk("long integ", INTEG_O, 1);
            i_trig.pulse(0);
            s = cyc;
            wait_sig(1);
            m = 0;
            d = 0;
            while (XFER_O === 1'b1 && m < 40) begin
                d = d | SCAN_DONE_O;
                step;
                m = m + 1;
            end
            chk("xfer length", m, 16);
            chk("scan done", d, 1);
            wait_sig(0);
            chk("fresh clear", CLEAR_O, 1);
            while (cyc - s < 395) step;
            chk("still integ", INTEG_O, 1);
            i_trig.pulse(0);
            wait_sig(1);
            repeat (2) step;
            chk("period", t1 - t0, 400);
            $display("test_sync finished");
        end
    endtask
    task test_hard;
        begin
            MODE_I = `ETAC_MODE_HARD;
            jmp = 2'h3;
            SRST_I = 1'b1;
            repeat (3) step;
            SRST_I = 1'b0;
            repeat (20) step;
            chk("hard idle", BUSY_O, 0);
            i_trig.pulse(1);
            wait_sig(0);
            chk("hard clear", CLEAR_O, 1);
            i_trig.pulse(1);
            i_trig.pulse(0);
            m = 0;
            repeat (20000) begin
                step;
                m = m + CLEAR_O + XFER_O;
            end
            chk("edges ignored", m, 0);
            chk("fixed integ", INTEG_O, 1);
            $display("test_hard finished");
        end
    endtask
    task test_free;
        begin
            MODE_I = `ETAC_MODE_NORMAL;
            CONV_I = `ETAC_CONV_MID;
            SRST_I = 1'b1;
            repeat (3) step;
            SRST_I = 1'b0;
            repeat (10) step;
            chk("free busy", BUSY_O, 1);
            chk("free integ", INTEG_O, 1);
            MODE_I = `ETAC_MODE_SOFT;
            CONV_I = `ETAC_CONV_SLOW;
            SRST_I = 1'b1;
            repeat (3) step;
            SRST_I = 1'b0;
            i_trig.pulse(2);
            chk("soft integ", INTEG_O, 1);
            $display("test_free finished");
        end
    endtask
    task final_report;
        begin
            $display("compares %0d n_mismatch %0d", compares, n_mismatch);
            if (n_mismatch == 0 && compares > 0) $display("Run complete: PASS");
            else $display("Run complete: FAIL");
            $finish;
        end
    endtask
    initial begin
        repeat (40000) @(posedge CLOCK_I);
        n_mismatch = n_mismatch + 1;
        final_report;
    end
    initial begin
        repeat (3) step;
        SRST_I = 1'b0;
        test_sync;
        test_hard;
        test_free;
        final_report;
    end
endmodule
